/* tmr34_channel.sv */
// One timer channel: counter and its three status flags
`timescale 1ns/10ps
`include "tmr34_params.svh"
module tmr34_channel #(
    parameter int CNT_W = 16,
    parameter bit CAN_UPDOWN = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire tmr34_pkg::tmr34_mode_t mode,
    input wire logic matchA,
    input wire logic matchB,
    input wire logic flagRead,
    input wire logic flagWrite,
    input wire logic [2:0] flagWdata,
    output logic [CNT_W-1:0] count,
    output logic [2:0] flags,
    output logic [2:0] flagSet
);
    import tmr34_pkg::*;

    localparam logic [CNT_W-1:0] ALL_ONES = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] ALL_ZERO = '0;

    logic countDown;
    logic armWrap;
    logic upDownOn;
    logic wrapNow;
    logic next_down;
    logic [CNT_W-1:0] next_count;
    logic [2:0] clrNow;

    // ==========================================
    // Counter
    assign upDownOn = CAN_UPDOWN && (mode == TMR34_MODE_CPWM);

    // Bottom turn of the up/down sweep is its underflow point
    always_comb begin
        next_count = count;
        next_down = countDown;
        wrapNow = 1'b0;
        if (run) begin
            if (upDownOn && countDown) begin
                if (count == ALL_ZERO) begin
                    next_down = 1'b0;
                    next_count = CNT_W'(count + 1'b1);
                    wrapNow = 1'b1;
                end else begin
                    next_count = CNT_W'(count - 1'b1);
                end
            end else if (upDownOn) begin
                if (count == ALL_ONES) begin
                    next_down = 1'b1;
                    next_count = CNT_W'(count - 1'b1);
                end else begin
                    next_count = CNT_W'(count + 1'b1);
                end
            end else begin
                next_down = 1'b0;
                next_count = CNT_W'(count + 1'b1);
                wrapNow = (count == ALL_ONES);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            countDown <= 1'b0;
        end else begin
            count <= next_count;
            countDown <= next_down;
        end
    end

    // ==========================================
    // Flags: set wins over a clear in the same cycle
    assign flagSet = {wrapNow, matchB, matchA};
    assign clrNow[`TMR34_FLG_WRAP] = flagWrite && !flagWdata[`TMR34_FLG_WRAP] && armWrap;
    assign clrNow[`TMR34_FLG_MB] = flagWrite && !flagWdata[`TMR34_FLG_MB];
    assign clrNow[`TMR34_FLG_MA] = flagWrite && !flagWdata[`TMR34_FLG_MA];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags <= 3'h0;
        end else begin
            flags <= flagSet | (flags & ~clrNow);
        end
    end

    // Arming needs a read that saw the flag at 1; any write disarms
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armWrap <= 1'b0;
        end else if (flagWrite) begin
            armWrap <= 1'b0;
        end else if (flagRead && flags[`TMR34_FLG_WRAP]) begin
            armWrap <= 1'b1;
        end
    end

    // ==========================================
    // Checks
    wrapSets_a: assert property (@(posedge ref_clk) disable iff (rst)
        run && !upDownOn && count == ALL_ONES |=> flags[`TMR34_FLG_WRAP] && count == ALL_ZERO)
        else $error("wrap did not set flag");
    noBlindClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        flagWrite && !armWrap && flags[`TMR34_FLG_WRAP] |=> flags[`TMR34_FLG_WRAP])
        else $error("flag cleared without prior read");
    armedClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        flagRead && flags[`TMR34_FLG_WRAP] ##1 flagWrite && !flagWdata[`TMR34_FLG_WRAP]
        && !wrapNow |=> !flags[`TMR34_FLG_WRAP])
        else $error("read then write 0 did not clear");
    oneKeeps_a: assert property (@(posedge ref_clk) disable iff (rst)
        flagWrite && flags[`TMR34_FLG_MA] && flagWdata[`TMR34_FLG_MA] |=> flags[`TMR34_FLG_MA])
        else $error("writing 1 changed flag");
    upCount_a: assert property (@(posedge ref_clk) disable iff (rst)
        run && !upDownOn |=> count == CNT_W'($past(count) + 1'b1))
        else $error("counter not counting up");
    downCount_a: assert property (@(posedge ref_clk) disable iff (rst)
        run && upDownOn && countDown && count != ALL_ZERO |=> count == CNT_W'($past(count) - 1'b1))
        else $error("counter not counting down");
endmodule

/* tmr34_ctrl.sv */
// Timer channels three and four with shared output enable and output control
`timescale 1ns/10ps
`include "tmr34_params.svh"
// Function
// - Wrap flag sets on counter wrap FFFF to 0000, or at the 0000 turn of the complementary PWM down count.
// - Wrap flag clears only after a read showing 1, then a written 0.
// - Flags ignore written ones; a written zero clears the match flags.
// - Channel three counts up/down in complementary PWM, otherwise up only.
// - Channel three pin A output blocked while its master gate is 0.
// - Channel four pin A output blocked while its master gate is 0.
// - Channel three and four pin B outputs blocked while their gates are 0.
// - Channel four complementary outputs blocked while their gates are 0.
// - External trigger clears master enable bits five down to zero.
module tmr34_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic ch3MatchA,
    input wire logic ch3MatchB,
    input wire logic ch4MatchA,
    input wire logic ch4MatchB,
    input wire logic ch2CaptureA,
    input wire logic [5:0] pinLevel,
    input wire logic [5:0] pinDrive,
    output logic [5:0] pinOut,
    output logic [5:0] pinOe,
    output logic irq
);
    import tmr34_pkg::*;

    logic [7:0] ch3CountControl;
    logic [7:0] ch3PinIoControl;
    logic [7:0] ch3IrqEnable;
    logic [7:0] ch4CountControl;
    logic [7:0] ch4PinIoControl;
    logic [7:0] ch4IrqEnable;
    logic [7:0] outputMasterEnable;
    logic [7:0] outputTriggerLevelControl;
    logic [7:0] timerModeSelect;
    logic [2:0] irqStatus;
    logic [2:0] irqEnable;
    logic [2:0] irqEvent;
    logic [2:0] ch3Flags;
    logic [2:0] ch4Flags;
    logic [2:0] ch3FlagSet;
    logic [2:0] ch4FlagSet;
    logic [15:0] ch3Count;
    logic [15:0] ch4Count;
    logic [5:0] activeLow;
    logic [7:0] next_rdata;
    tmr34_mode_t mode;
    logic pwmMode;
    logic extTrigger;
    logic wrEn;

    assign wrEn = regWrite;
    assign mode = tmr34_mode_t'(timerModeSelect[1:0]);
    assign pwmMode = (mode == TMR34_MODE_RSYNC) || (mode == TMR34_MODE_CPWM);

    // ==========================================
    // Channels
    tmr34_channel #(
        .CNT_W(16),
        .CAN_UPDOWN(1'b1)
    ) u_ch3 (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(timerModeSelect[`TMR34_RUN3]),
        .mode(mode),
        .matchA(ch3MatchA),
        .matchB(ch3MatchB),
        .flagRead(regRead && regAddr == `TMR34_A_FLG3),
        .flagWrite(wrEn && regAddr == `TMR34_A_FLG3),
        .flagWdata(regWdata[2:0]),
        .count(ch3Count),
        .flags(ch3Flags),
        .flagSet(ch3FlagSet)
    );

    tmr34_channel #(
        .CNT_W(16),
        .CAN_UPDOWN(1'b0)
    ) u_ch4 (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(timerModeSelect[`TMR34_RUN4]),
        .mode(mode),
        .matchA(ch4MatchA),
        .matchB(ch4MatchB),
        .flagRead(regRead && regAddr == `TMR34_A_FLG4),
        .flagWrite(wrEn && regAddr == `TMR34_A_FLG4),
        .flagWdata(regWdata[2:0]),
        .count(ch4Count),
        .flags(ch4Flags),
        .flagSet(ch4FlagSet)
    );

    // ==========================================
    // Plain control registers
    // One process per register keeps each write decode next to its state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch3CountControl <= `TMR34_TCR_RST;
        end else if (wrEn && regAddr == `TMR34_A_TCR3) begin
            ch3CountControl <= regWdata | ~`TMR34_TCR_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch3PinIoControl <= `TMR34_TIOR_RST;
        end else if (wrEn && regAddr == `TMR34_A_CH3_PIN_IO_CONTROL) begin
            ch3PinIoControl <= regWdata | ~`TMR34_TIOR_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch3IrqEnable <= `TMR34_TIER_RST;
        end else if (wrEn && regAddr == `TMR34_A_CH3_IRQ_ENABLE) begin
            ch3IrqEnable <= regWdata | ~`TMR34_TIER_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch4CountControl <= `TMR34_TCR_RST;
        end else if (wrEn && regAddr == `TMR34_A_CH4_COUNT_CONTROL) begin
            ch4CountControl <= regWdata | ~`TMR34_TCR_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch4PinIoControl <= `TMR34_TIOR_RST;
        end else if (wrEn && regAddr == `TMR34_A_CH4_PIN_IO_CONTROL) begin
            ch4PinIoControl <= regWdata | ~`TMR34_TIOR_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ch4IrqEnable <= `TMR34_TIER_RST;
        end else if (wrEn && regAddr == `TMR34_A_CH4_IRQ_ENABLE) begin
            ch4IrqEnable <= regWdata | ~`TMR34_TIER_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            outputTriggerLevelControl <= `TMR34_OUTPUT_TRIGGER_LEVEL_CONTROL_RST;
        end else if (wrEn && regAddr == `TMR34_A_OUTPUT_TRIGGER_LEVEL_CONTROL) begin
            outputTriggerLevelControl <= regWdata | ~`TMR34_OUTPUT_TRIGGER_LEVEL_CONTROL_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timerModeSelect <= `TMR34_MODE_RST;
        end else if (wrEn && regAddr == `TMR34_A_MODE) begin
            timerModeSelect <= regWdata & `TMR34_MODE_MASK;
        end
    end

    // ==========================================
    // Master output enables and external trigger
    // Hardware trigger beats a software write in the same cycle, so outputs
    // cannot be re-enabled by a racing write.
    assign extTrigger = !outputTriggerLevelControl[`TMR34_EXT_TRIGGER_DISABLE]
        && ch2CaptureA && pwmMode;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            outputMasterEnable <= `TMR34_OUTPUT_MASTER_ENABLE_RST;
        end else if (extTrigger) begin
            outputMasterEnable <= outputMasterEnable & ~`TMR34_OUTPUT_MASTER_ENABLE_MASK;
        end else if (wrEn && regAddr == `TMR34_A_OUTPUT_MASTER_ENABLE) begin
            outputMasterEnable <= regWdata | ~`TMR34_OUTPUT_MASTER_ENABLE_MASK;
        end
    end

    // ==========================================
    // Pin gating and polarity
    // Level select 1 keeps the level direct, 0 inverts it in PWM modes
    assign activeLow = {{4{!outputTriggerLevelControl[`TMR34_CH4_LEVEL_SELECT]}},
        {2{!outputTriggerLevelControl[`TMR34_CH3_LEVEL_SELECT]}}};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinOut <= 6'h00;
            pinOe <= 6'h00;
        end else begin
            pinOut <= pinLevel ^ (activeLow & {6{pwmMode}});
            pinOe <= pinDrive & outputMasterEnable[5:0];
        end
    end

    // ==========================================
    // Interrupt status, clear and enable
    assign irqEvent = {extTrigger, |(ch4FlagSet & ch4IrqEnable[2:0]),
        |(ch3FlagSet & ch3IrqEnable[2:0])};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqStatus <= `TMR34_IRQ_RST;
        end else if (wrEn && regAddr == `TMR34_A_ICLR) begin
            irqStatus <= irqEvent | (irqStatus & ~regWdata[2:0]);
        end else begin
            irqStatus <= irqEvent | irqStatus;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqEnable <= `TMR34_IRQ_RST;
        end else if (wrEn && regAddr == `TMR34_A_IEN) begin
            irqEnable <= regWdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqEnable);
        end
    end

    // ==========================================
    // Read path: data only in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        unique case (regAddr)
            `TMR34_A_TCR3: next_rdata = ch3CountControl;
            `TMR34_A_CH3_PIN_IO_CONTROL: next_rdata = ch3PinIoControl;
            `TMR34_A_CH3_IRQ_ENABLE: next_rdata = ch3IrqEnable;
            `TMR34_A_FLG3: next_rdata = {`TMR34_FLG_PAD, ch3Flags};
            `TMR34_A_CNT3H: next_rdata = ch3Count[15:8];
            `TMR34_A_CNT3L: next_rdata = ch3Count[7:0];
            `TMR34_A_OUTPUT_MASTER_ENABLE: next_rdata = outputMasterEnable;
            `TMR34_A_OUTPUT_TRIGGER_LEVEL_CONTROL: next_rdata = outputTriggerLevelControl;
            `TMR34_A_CH4_COUNT_CONTROL: next_rdata = ch4CountControl;
            `TMR34_A_CH4_PIN_IO_CONTROL: next_rdata = ch4PinIoControl;
            `TMR34_A_CH4_IRQ_ENABLE: next_rdata = ch4IrqEnable;
            `TMR34_A_FLG4: next_rdata = {`TMR34_FLG_PAD, ch4Flags};
            `TMR34_A_CNT4H: next_rdata = ch4Count[15:8];
            `TMR34_A_CNT4L: next_rdata = ch4Count[7:0];
            `TMR34_A_MODE: next_rdata = timerModeSelect;
            `TMR34_A_ISTAT: next_rdata = {5'h00, irqStatus};
            `TMR34_A_IEN: next_rdata = {5'h00, irqEnable};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ==========================================
    // Checks
    gateA3_a: assert property (@(posedge ref_clk) disable iff (rst)
        !outputMasterEnable[0] |=> !pinOe[0])
        else $error("ch3 pin A driven while gated");
    gateA4_a: assert property (@(posedge ref_clk) disable iff (rst)
        !outputMasterEnable[2] |=> !pinOe[2])
        else $error("ch4 pin A driven while gated");
    gateB_a: assert property (@(posedge ref_clk) disable iff (rst)
        outputMasterEnable[1] && pinDrive[1] && !outputMasterEnable[3] |=> pinOe[1] && !pinOe[3])
        else $error("pin B gating wrong");
    gateComp_a: assert property (@(posedge ref_clk) disable iff (rst)
        pinDrive[4] && pinDrive[5] |=> pinOe[5:4] == $past(outputMasterEnable[5:4]))
        else $error("complementary gating wrong");
    trigClear_a: assert property (@(posedge ref_clk) disable iff (rst)
        extTrigger |=> outputMasterEnable[5:0] == 6'h00 ##1 pinOe == 6'h00)
        else $error("trigger did not clear enables");
    trigOff_a: assert property (@(posedge ref_clk) disable iff (rst)
        outputTriggerLevelControl[`TMR34_EXT_TRIGGER_DISABLE] && !(wrEn && regAddr == `TMR34_A_OUTPUT_MASTER_ENABLE)
        |=> $stable(outputMasterEnable))
        else $error("enables moved while trigger disabled");
    trigSource_a: assert property (@(posedge ref_clk) disable iff (rst)
        ch2CaptureA && !outputTriggerLevelControl[`TMR34_EXT_TRIGGER_DISABLE] && pwmMode
        |=> outputMasterEnable[5:0] == 6'h00)
        else $error("capture did not act as trigger");
    polarity_a: assert property (@(posedge ref_clk) disable iff (rst)
        pwmMode && !outputTriggerLevelControl[`TMR34_CH3_LEVEL_SELECT] |=> pinOut[0] == !$past(pinLevel[0]))
        else $error("level select not applied");
    readLatency_a: assert property (@(posedge ref_clk) disable iff (rst)
        !regRead |=> regRdata == 8'h00)
        else $error("read data outside read cycle");
    trigWins_a: assert property (@(posedge ref_clk) disable iff (rst)
        extTrigger && wrEn && regAddr == `TMR34_A_OUTPUT_MASTER_ENABLE |=> outputMasterEnable[5:0] == 6'h00)
        else $error("enable write beat the trigger");
    gateB3_a: assert property (@(posedge ref_clk) disable iff (rst)
        !outputMasterEnable[1] |=> !pinOe[1])
        else $error("ch3 pin B driven while gated");
    gateB4_a: assert property (@(posedge ref_clk) disable iff (rst)
        !outputMasterEnable[3] |=> !pinOe[3])
        else $error("ch4 pin B driven while gated");
    gateCompA_a: assert property (@(posedge ref_clk) disable iff (rst)
        !outputMasterEnable[4] |=> !pinOe[4])
        else $error("ch4 comp A driven while gated");
    gateCompB_a: assert property (@(posedge ref_clk) disable iff (rst)
        !outputMasterEnable[5] |=> !pinOe[5])
        else $error("ch4 comp B driven while gated");
    polarity4_a: assert property (@(posedge ref_clk) disable iff (rst)
        pwmMode && !outputTriggerLevelControl[`TMR34_CH4_LEVEL_SELECT] |=> pinOut[2] == !$past(pinLevel[2]))
        else $error("ch4 level select not applied");
    directLevel_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pwmMode |=> pinOut == $past(pinLevel))
        else $error("level changed outside PWM modes");
    trigStatus_a: assert property (@(posedge ref_clk) disable iff (rst)
        extTrigger |=> irqStatus[2])
        else $error("trigger not recorded in status");
    ch3Status_a: assert property (@(posedge ref_clk) disable iff (rst)
        |(ch3FlagSet & ch3IrqEnable[2:0]) |=> irqStatus[0])
        else $error("ch3 event not recorded in status");
    ch4Status_a: assert property (@(posedge ref_clk) disable iff (rst)
        |(ch4FlagSet & ch4IrqEnable[2:0]) |=> irqStatus[1])
        else $error("ch4 event not recorded in status");
    irqRaise_a: assert property (@(posedge ref_clk) disable iff (rst)
        (irqStatus & irqEnable) != 3'h0 |=> irq)
        else $error("interrupt missing");
    irqQuiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        (irqStatus & irqEnable) == 3'h0 |=> !irq)
        else $error("interrupt without enabled status");
    enableWrite_a: assert property (@(posedge ref_clk) disable iff (rst)
        wrEn && regAddr == `TMR34_A_IEN |=> irqEnable == $past(regWdata[2:0]))
        else $error("interrupt enable write lost");

    trigSeen_c: cover property (@(posedge ref_clk) disable iff (rst) extTrigger);
    irqSeen_c: cover property (@(posedge ref_clk) disable iff (rst) irq);
    wrap3Seen_c: cover property (@(posedge ref_clk) disable iff (rst) ch3Flags[`TMR34_FLG_WRAP]);
    wrap4Seen_c: cover property (@(posedge ref_clk) disable iff (rst) ch4Flags[`TMR34_FLG_WRAP]);
    cpwmRun_c: cover property (@(posedge ref_clk) disable iff (rst)
        mode == TMR34_MODE_CPWM && timerModeSelect[`TMR34_RUN3]);
endmodule

/* tmr34_ctrl_tb.sv */
// Self-checking testbench for the timer channel three/four output control block
`timescale 1ns/10ps
module tmr34_ctrl_tb;
    // ==========================================
    // Signals
    logic refClk;
    logic rst;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic regWrite;
    logic regRead;
    logic [7:0] regRdata;
    logic [4:0] evt;
    logic [5:0] pinLevel;
    logic [5:0] pinDrive;
    logic [5:0] pinOut;
    logic [5:0] pinOe;
    logic irq;
    int errors;
    int cmpCount;
    int cycles;
    logic [7:0] lowA;
    logic [7:0] lowB;
    // Reset table: address and expected value
    localparam logic [7:0] RST_ADDR [12] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h90, 8'h91,
                                             8'h92, 8'h93, 8'h94, 8'h95, 8'ha8, 8'h50};
    localparam logic [7:0] RST_VAL [12] = '{8'h80, 8'h88, 8'hf8, 8'hf8, 8'hff, 8'hff,
                                            8'h80, 8'h88, 8'hf8, 8'hf8, 8'h00, 8'h00};
    // Hang guard, run needs about 66000 cycles
    localparam int MAX_CYCLES = 72000;

    tmr34_ctrl i_dut (
        .ref_clk(refClk),
        .rst(rst),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdata(regRdata),
        .ch3MatchA(evt[0]),
        .ch3MatchB(evt[1]),
        .ch4MatchA(evt[2]),
        .ch4MatchB(evt[3]),
        .ch2CaptureA(evt[4]),
        .pinLevel(pinLevel),
        .pinDrive(pinDrive),
        .pinOut(pinOut),
        .pinOe(pinOe),
        .irq(irq)
    );

    // ==========================================
    // Clock and hang guard
    initial begin
        refClk = 1'b0;
        forever #4 refClk = ~refClk;
    end

    always @(posedge refClk) begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    // ==========================================
    // Bus and check tasks
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmpCount = cmpCount + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge refClk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge refClk);
        regWrite <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge refClk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge refClk);
        regRead <= 1'b0;
        #1;
        v = regRdata;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk($sformatf("reg %h", a), exp, v);
    endtask

    task automatic pulse(input int i);
        @(posedge refClk);
        evt[i] <= 1'b1;
        @(posedge refClk);
        evt[i] <= 1'b0;
    endtask

    // Pins follow their sources one cycle late
    task automatic pinChk(input logic [5:0] expOut, input logic [5:0] expOe);
        repeat (2) @(posedge refClk);
        #1;
        chk("pinOut", {2'b00, expOut}, {2'b00, pinOut});
        chk("pinOe", {2'b00, expOe}, {2'b00, pinOe});
    endtask

    task automatic irqChk(input logic exp);
        @(posedge refClk);
        #1;
        chk("irq", {7'h00, exp}, {7'h00, irq});
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && cmpCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        evt = 5'h00;
        pinLevel = 6'h3f;
        pinDrive = 6'h3f;
        errors = 0;
        cmpCount = 0;
        cycles = 0;
        repeat (5) @(posedge refClk);
        rst <= 1'b0;

        // Reset values, unmapped address reads zero
        for (int i = 0; i < 12; i++) begin
            rdChk(RST_ADDR[i], RST_VAL[i]);
        end
        pinChk(6'h3f, 6'h3f);
        wr(8'h83, 8'hff);
        rdChk(8'h83, 8'hff);
        wr(8'h93, 8'h00);
        rdChk(8'h93, 8'h88);

        // Each master gate alone lets only its own pin drive
        for (int i = 0; i < 6; i++) begin
            wr(8'h90, 8'h01 << i);
            pinChk(6'h3f, 6'h01 << i);
        end
        wr(8'h90, 8'h00);
        rdChk(8'h90, 8'hc0);
        wr(8'h90, 8'hff);

        // Polarity in reset-sync mode, trigger gating by disable bit and mode, trigger firing in complementary PWM
        wr(8'ha8, 8'h01);
        pinChk(6'h3f, 6'h3f);
        wr(8'h91, 8'hfe);
        pinChk(6'h3c, 6'h3f);
        pulse(4);
        rdChk(8'h90, 8'hff);
        wr(8'h91, 8'hed);
        rdChk(8'h91, 8'hed);
        pinChk(6'h03, 6'h3f);
        wr(8'ha8, 8'h00);
        pinChk(6'h3f, 6'h3f);
        pulse(4);
        rdChk(8'h90, 8'hff);
        wr(8'ha8, 8'h03);
        pulse(4);
        rdChk(8'h90, 8'hff);
        wr(8'ha8, 8'h02);
        pulse(4);
        rdChk(8'h90, 8'hc0);
        pinChk(6'h03, 6'h00);
        rdChk(8'hb0, 8'h04);
        wr(8'hb1, 8'h04);
        rdChk(8'hb0, 8'h00);
        wr(8'h90, 8'hff);
        wr(8'h91, 8'hff);
        wr(8'ha8, 8'h00);

        // Match flags take only written zeros
        wr(8'h84, 8'h01);
        pulse(0);
        pulse(1);
        rdChk(8'h85, 8'hfb);
        wr(8'h85, 8'hff);
        rdChk(8'h85, 8'hfb);
        wr(8'h85, 8'hfa);
        rdChk(8'h85, 8'hfa);
        wr(8'h85, 8'hf8);
        rdChk(8'h85, 8'hf8);
        rdChk(8'hb0, 8'h01);
        wr(8'hb1, 8'h01);
        rdChk(8'hb0, 8'h00);
        pulse(2);
        pulse(3);
        rdChk(8'h95, 8'hfb);
        wr(8'h95, 8'hfd);
        rdChk(8'h95, 8'hf9);
        wr(8'h95, 8'hf8);
        rdChk(8'h95, 8'hf8);

        // Both counters run: ch4 wraps up, ch3 turns down at the top
        wr(8'h94, 8'h04);
        wr(8'hb2, 8'h02);
        wr(8'ha8, 8'h0e);
        repeat (65560) @(posedge refClk);
        irqChk(1'b1);
        wr(8'h95, 8'hf8);
        rdChk(8'h95, 8'hfc);
        wr(8'h95, 8'hf8);
        rdChk(8'h95, 8'hf8);
        rdChk(8'h85, 8'hf8);
        rdChk(8'h86, 8'hff);
        rd(8'h87, lowA);
        rd(8'h87, lowB);
        chk("ch3 count step", 8'h02, lowA - lowB);
        rdChk(8'hb0, 8'h02);
        wr(8'hb2, 8'h00);
        irqChk(1'b0);
        wr(8'hb2, 8'h02);
        irqChk(1'b1);
        wr(8'hb1, 8'h02);
        irqChk(1'b0);
        rdChk(8'hb0, 8'h00);
        tally_and_finish();
    end
endmodule

/* tmr34_params.svh */
// Register offsets, field positions and reset values of the timer output block
`ifndef TMR34_PARAMS_SVH
`define TMR34_PARAMS_SVH

// ==========================================
// Register offsets
`define TMR34_A_TCR3 8'h82
`define TMR34_A_CH3_PIN_IO_CONTROL 8'h83
`define TMR34_A_CH3_IRQ_ENABLE 8'h84
`define TMR34_A_FLG3 8'h85
`define TMR34_A_CNT3H 8'h86
`define TMR34_A_CNT3L 8'h87
`define TMR34_A_OUTPUT_MASTER_ENABLE 8'h90
`define TMR34_A_OUTPUT_TRIGGER_LEVEL_CONTROL 8'h91
`define TMR34_A_CH4_COUNT_CONTROL 8'h92
`define TMR34_A_CH4_PIN_IO_CONTROL 8'h93
`define TMR34_A_CH4_IRQ_ENABLE 8'h94
`define TMR34_A_FLG4 8'h95
`define TMR34_A_CNT4H 8'h96
`define TMR34_A_CNT4L 8'h97
`define TMR34_A_MODE 8'ha8
`define TMR34_A_ISTAT 8'hb0
`define TMR34_A_ICLR 8'hb1
`define TMR34_A_IEN 8'hb2

// ==========================================
// Writable masks and fixed bits (fixed bits read as 1, except in the mode, interrupt status and interrupt enable registers where they read as 0)
`define TMR34_TCR_MASK 8'h7f
`define TMR34_TCR_RST 8'h80
`define TMR34_TIOR_MASK 8'h77
`define TMR34_TIOR_RST 8'h88
`define TMR34_TIER_MASK 8'h07
`define TMR34_TIER_RST 8'hf8
`define TMR34_FLG_PAD 5'h1f
`define TMR34_OUTPUT_MASTER_ENABLE_MASK 8'h3f
`define TMR34_OUTPUT_MASTER_ENABLE_RST 8'hff
`define TMR34_OUTPUT_TRIGGER_LEVEL_CONTROL_MASK 8'h13
`define TMR34_OUTPUT_TRIGGER_LEVEL_CONTROL_RST 8'hff
`define TMR34_MODE_MASK 8'h0f
`define TMR34_MODE_RST 8'h00
`define TMR34_IRQ_RST 3'h0

// ==========================================
// Field positions
`define TMR34_FLG_WRAP 2
`define TMR34_FLG_MB 1
`define TMR34_FLG_MA 0
`define TMR34_EXT_TRIGGER_DISABLE 4
`define TMR34_CH4_LEVEL_SELECT 1
`define TMR34_CH3_LEVEL_SELECT 0
`define TMR34_RUN3 2
`define TMR34_RUN4 3

`endif

/* tmr34_pkg.sv */
// Types shared by the timer output block
package tmr34_pkg;
    typedef enum logic [1:0] {
        TMR34_MODE_NORMAL,
        TMR34_MODE_RSYNC,
        TMR34_MODE_CPWM,
        TMR34_MODE_RSVD
    } tmr34_mode_t;
endpackage
